// *** rtl/plc_link_control.sv ***
// Purpose: Per-port link control register with APB slave and PHY controls
// Assumes: Single core clock; EEPROM preset inputs synchronous
// Notes: Registers at link control, switch control, port mode, phy status
// What this block does
// [RULE1] Two-bit power state control, reset disabled
// [RULE2] EEPROM value may replace power default
// [RULE3] Read completion boundary bit reads zero
// [RULE4] Downstream link disable holds link down
// [RULE5] Upstream link disable needs unlock bit
// [RULE6] Retrain write sends LTSSM to Recovery
// [RULE7] Retrain bit is trigger, reads zero
// [RULE8] Same-write field changes apply to retrain
// [RULE9] Upstream retrain needs unlock bit
// [RULE10] Shared reference clock bit, reset zero
// [RULE11] Extended sync adds ordered sets
// [RULE12] Clock power management bit reads zero
// [RULE13] Width block stops autonomous width changes
// [RULE14] Compatibility mode forces width block zero
// [RULE15] Reserved bit two reads zero, ignored
`timescale 1ns/1ns
`default_nettype none
module plc_link_control #(
	parameter int unsigned ADDR_WIDTH = plc_pkg::ADDR_W
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_WIDTH-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_eeprom_load,
	input wire logic [1:0] i_eeprom_aspm,
	input wire logic i_phy_in_recovery,
	output plc_pkg::plc_phy_ctl_t o_phy_ctl
);
	if (ADDR_WIDTH < 12)
	begin : g_addr_check
		$error("ADDR_WIDTH too small for register map");
	end

	typedef enum logic [1:0] {
		PLC_IDLE = 2'b01,
		PLC_ACCESS = 2'b10
	} plc_state_t;

	plc_state_t state_reg;
	plc_state_t state_next;
	plc_pkg::plc_fields_t fields_reg;
	plc_pkg::plc_fields_t fields_next;
	logic unlock_reg;
	logic upstream_reg;
	logic compat11_reg;
	logic retrain_reg;
	logic in_recovery_seen;
	logic setup;
	logic wr_fire;
	logic lo_lane;
	logic hi_lane;
	logic [11:0] addr;
	logic hit_ctl;
	logic hit_sw;
	logic hit_mode;
	logic hit_phy;
	logic hit_any;
	logic up_locked;
	logic retrain_req;
	logic [31:0] rdata_next;
	logic [15:0] ctl_view;

	assign addr = i_paddr[11:0];
	assign setup = i_psel && !i_penable;
	assign hit_ctl = addr == plc_pkg::LINK_CONTROL_ADDR;
	assign hit_sw = addr == plc_pkg::SWITCH_CONTROL_ADDR;
	assign hit_mode = addr == plc_pkg::PORT_MODE_ADDR;
	assign hit_phy = addr == plc_pkg::PHY_STATUS_ADDR;
	assign hit_any = hit_ctl || hit_sw || hit_mode || hit_phy;
	assign wr_fire = (state_reg == PLC_ACCESS) && i_psel && i_penable && i_pwrite;
	assign lo_lane = i_pstrb[0];
	assign hi_lane = i_pstrb[1];
	assign up_locked = upstream_reg && !unlock_reg;

	// APB: setup then one access cycle, pready on the access cycle
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			PLC_IDLE:
				if (setup)
					state_next = PLC_ACCESS;
			PLC_ACCESS:
				state_next = setup ? PLC_ACCESS : PLC_IDLE;
			default:
				state_next = PLC_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state_reg <= PLC_IDLE;
		else
			state_reg <= state_next;
	end

	// Field update, byte lanes honoured
	always_comb
	begin
		fields_next = fields_reg;
		if (i_eeprom_load)
			fields_next.aspm_mode = i_eeprom_aspm; // [RULE2]
		if (wr_fire && hit_ctl)
		begin
			if (lo_lane)
			begin
				fields_next.aspm_mode = i_pwdata[plc_pkg::ASPM_LSB +: 2]; // [RULE1]
				fields_next.link_disable_bit = up_locked ? 1'b0
					: i_pwdata[plc_pkg::LINK_DISABLE_POS]; // [RULE4] [RULE5]
				fields_next.shared_refclk_bit = i_pwdata[plc_pkg::REFCLK_BIT]; // [RULE10]
				fields_next.extended_sync_bit = i_pwdata[plc_pkg::EXT_SYNC_POS]; // [RULE11]
			end
			if (hi_lane)
				fields_next.autonomous_width_block_bit = compat11_reg ? 1'b0
					: i_pwdata[plc_pkg::AWB_BIT]; // [RULE14]
		end
		if (up_locked)
			fields_next.link_disable_bit = 1'b0; // [RULE5]
		if (compat11_reg)
			fields_next.autonomous_width_block_bit = 1'b0; // [RULE14]
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			fields_reg <= '{aspm_mode: plc_pkg::ASPM_RESET, default: 1'b0}; // [RULE1] [RULE10]
		else
			fields_reg <= fields_next;
	end

	plc_sync_bit #(.RESET_VAL(1'b0)) u_unlock (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_load(wr_fire && hit_sw && lo_lane),
		.i_value(i_pwdata[plc_pkg::UNLOCK_BIT]),
		.o_q(unlock_reg)
	);

	plc_sync_bit #(.RESET_VAL(1'b0)) u_upstream (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_load(wr_fire && hit_mode && lo_lane),
		.i_value(i_pwdata[plc_pkg::UPSTREAM_BIT]),
		.o_q(upstream_reg)
	);

	plc_sync_bit #(.RESET_VAL(1'b0)) u_compat11 (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_load(wr_fire && hit_mode && lo_lane),
		.i_value(i_pwdata[plc_pkg::COMPAT11_BIT]),
		.o_q(compat11_reg)
	);

	// Retrain is a one-cycle trigger, reads zero in link control; a one-cycle flopped copy reads as phy status bit 1
	assign retrain_req = wr_fire && hit_ctl && lo_lane
		&& i_pwdata[plc_pkg::RETRAIN_BIT] && !up_locked; // [RULE6] [RULE9]

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			retrain_reg <= 1'b0;
		else
			retrain_reg <= retrain_req; // [RULE6]
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			in_recovery_seen <= 1'b0;
		else
			in_recovery_seen <= i_phy_in_recovery;
	end

	// Controls leave from flops; fields and trigger share the same edge
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_phy_ctl <= '0;
		else
		begin
			o_phy_ctl.l0s_entry_en <= fields_next.aspm_mode[0]; // [RULE1]
			o_phy_ctl.l1_entry_en <= fields_next.aspm_mode[1]; // [RULE1]
			o_phy_ctl.link_disabled <= fields_next.link_disable_bit; // [RULE4] [RULE5]
			o_phy_ctl.retrain_pulse <= retrain_req; // [RULE6] [RULE8]
			o_phy_ctl.shared_refclk <= fields_next.shared_refclk_bit; // [RULE8]
			o_phy_ctl.extended_sync <= fields_next.extended_sync_bit; // [RULE11]
			o_phy_ctl.width_change_blocked <= fields_next.autonomous_width_block_bit; // [RULE13]
		end
	end

	// Read view of link control
	always_comb
	begin
		ctl_view = '0; // [RULE3] [RULE7] [RULE12] [RULE15]
		ctl_view[plc_pkg::ASPM_LSB +: 2] = fields_reg.aspm_mode;
		ctl_view[plc_pkg::LINK_DISABLE_POS] = fields_reg.link_disable_bit && !up_locked; // [RULE5]
		ctl_view[plc_pkg::REFCLK_BIT] = fields_reg.shared_refclk_bit;
		ctl_view[plc_pkg::EXT_SYNC_POS] = fields_reg.extended_sync_bit;
		ctl_view[plc_pkg::AWB_BIT] = fields_reg.autonomous_width_block_bit && !compat11_reg; // [RULE14]
	end

	always_comb
	begin
		rdata_next = plc_pkg::BAD_ADDR_DATA;
		if (hit_ctl)
			rdata_next = {16'h0000, ctl_view};
		else if (hit_sw)
			rdata_next = {31'h0000_0000, unlock_reg};
		else if (hit_mode)
			rdata_next = {30'h0000_0000, compat11_reg, upstream_reg};
		else if (hit_phy)
			rdata_next = {30'h0000_0000, retrain_reg, in_recovery_seen};
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_prdata <= '0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end
		else
		begin
			o_pready <= setup;
			o_pslverr <= setup && !hit_any;
			o_prdata <= (setup && !i_pwrite) ? rdata_next : '0;
		end
	end
endmodule : plc_link_control
`default_nettype wire

// *** include/plc_pkg.sv ***
// Purpose: Constants and carriers for the port link control register block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Byte addresses equal printed offsets
package plc_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] LINK_CONTROL_ADDR = 12'h050;
	localparam logic [11:0] SWITCH_CONTROL_ADDR = 12'h100;
	localparam logic [11:0] PORT_MODE_ADDR = 12'h104;
	localparam logic [11:0] PHY_STATUS_ADDR = 12'h108;
	localparam int unsigned ASPM_LSB = 0;
	localparam int unsigned RSVD_BIT = 2;
	localparam int unsigned RCB_BIT = 3;
	localparam int unsigned LINK_DISABLE_POS = 4;
	localparam int unsigned RETRAIN_BIT = 5;
	localparam int unsigned REFCLK_BIT = 6;
	localparam int unsigned EXT_SYNC_POS = 7;
	localparam int unsigned CLKPM_BIT = 8;
	localparam int unsigned AWB_BIT = 9;
	localparam int unsigned UNLOCK_BIT = 0;
	localparam int unsigned UPSTREAM_BIT = 0;
	localparam int unsigned COMPAT11_BIT = 1;
	localparam logic [1:0] ASPM_RESET = 2'h0;
	localparam logic [1:0] ASPM_L0S = 2'h1;
	localparam logic [1:0] ASPM_L1 = 2'h2;
	localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;

	typedef struct packed {
		logic [1:0] aspm_mode;
		logic link_disable_bit;
		logic shared_refclk_bit;
		logic extended_sync_bit;
		logic autonomous_width_block_bit;
	} plc_fields_t;

	typedef struct packed {
		logic l0s_entry_en;
		logic l1_entry_en;
		logic link_disabled;
		logic retrain_pulse;
		logic shared_refclk;
		logic extended_sync;
		logic width_change_blocked;
	} plc_phy_ctl_t;
endpackage : plc_pkg

// *** rtl/plc_sync_bit.sv ***
// Purpose: Single control bit flop with set and clear, reset to constant
// Assumes: One clock, asynchronous active-low reset
// Notes: Load wins over hold
`timescale 1ns/1ns
`default_nettype none
module plc_sync_bit #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic i_value,
	output logic o_q
);
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_q <= RESET_VAL;
		else if (i_load)
			o_q <= i_value;
	end
endmodule : plc_sync_bit
`default_nettype wire

// *** test/plc_phy_model.sv ***
// Purpose: Far-side PHY stand-in reporting recovery
// Assumes: Recovery lasts SPAN cycles after a retrain pulse
// Notes: SPAN sets prompt or slow answers
`timescale 1ns/1ns
`default_nettype none
module plc_phy_model #(
	parameter int unsigned SPAN = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_retrain,
	output logic o_in_recovery
);
	int unsigned cnt_reg;
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n)
			cnt_reg <= 0;
		else if (i_retrain)
			cnt_reg <= SPAN;
		else if (cnt_reg != 0)
			cnt_reg <= cnt_reg - 1;
	assign o_in_recovery = cnt_reg != 0;
endmodule : plc_phy_model
`default_nettype wire

// *** test/plc_link_control_assertions.sv ***
// Purpose: Port checks for the link control register
// Assumes: Zero-wait APB slave
// Notes: Bound into the register block
`timescale 1ns/1ns
`default_nettype none
module plc_link_control_assertions #(
	parameter int unsigned ADDR_WIDTH = 12
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_WIDTH-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire plc_pkg::plc_phy_ctl_t o_phy_ctl
);
	logic hit, wr, rd, rtw;
	assign hit = i_psel && i_penable && o_pready && i_paddr == 12'h050;
	assign wr = hit && i_pwrite;
	assign rd = hit && !i_pwrite;
	assign rtw = wr && i_pwdata[5];
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> o_pready)
		else $error("ready missing after setup");
	a_ready_one_cycle: assert property (o_pready |=> !o_pready)
		else $error("ready held too long");
	a_rsvd_reads_zero: assert property (rd |-> !o_prdata[2])
		else $error("reserved bit read one");
	a_rcb_reads_zero: assert property (rd |-> !o_prdata[3])
		else $error("boundary bit read one");
	a_retrain_reads_zero: assert property (rd |-> !o_prdata[5])
		else $error("retrain bit read one");
	a_clkpm_reads_zero: assert property (rd |-> !o_prdata[8])
		else $error("clock pm bit read one");
	a_retrain_cause: assert property (o_phy_ctl.retrain_pulse |-> $past(rtw))
		else $error("retrain without write");
	a_aspm_decode: assert property (wr && i_pstrb[0] |=>
		o_phy_ctl.l0s_entry_en == $past(i_pwdata[0]) && o_phy_ctl.l1_entry_en == $past(i_pwdata[1]))
		else $error("power entry enables wrong");
	a_same_write: assert property (o_phy_ctl.retrain_pulse |->
		o_phy_ctl.extended_sync == $past(i_pwdata[7]) && o_phy_ctl.shared_refclk == $past(i_pwdata[6]))
		else $error("retrain missed same-write fields");
endmodule : plc_link_control_assertions
bind plc_link_control plc_link_control_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_phy_ctl(o_phy_ctl));
`default_nettype wire

// *** test/plc_link_control_tb.sv ***
// Purpose: Self-checking bench for the link control register
// Assumes: Zero-wait APB slave, downstream port after reset
// Notes: Each write snapshots the PHY controls
`timescale 1ns/1ns
`default_nettype none
module plc_link_control_tb;
	localparam logic [11:0] LC = plc_pkg::LINK_CONTROL_ADDR;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ld = 1'b0;
	logic rec, pready, pslverr, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q, snap;
	logic [1:0] easpm = 2'h0;
	logic [3:0] strb = 4'hf;
	plc_pkg::plc_phy_ctl_t phy;
	int miscompares = 0, checks = 0;
	always #20 clk = ~clk;
	plc_link_control u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(strb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_eeprom_load(ld), .i_eeprom_aspm(easpm), .i_phy_in_recovery(rec), .o_phy_ctl(phy));
	plc_phy_model u_phy (.i_clk_sys(clk), .i_rst_n(rst_n), .i_retrain(phy.retrain_pulse),
		.o_in_recovery(rec));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
		snap = {25'h0, phy};
		@(posedge clk);
	endtask : xfer
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic t_eeprom;
		ld <= 1'b1;
		easpm <= 2'h2;
		@(posedge clk);
		ld <= 1'b0;
		xfer(1'b0, LC, 32'h0);
		chk("link control", 32'h2, q);
	endtask : t_eeprom
	task automatic t_fields;
		xfer(1'b1, LC, 32'hffff_ffff);
		chk("phy ctl", 32'h7f, snap);
		xfer(1'b0, LC, 32'h0);
		chk("link control", 32'h2d3, q);
		for (int v = 0; v < 4; v++)
		begin
			xfer(1'b1, LC, v);
			chk("power enables", {v[0], v[1]}, snap[6:5]);
		end
		strb <= 4'h2;
		xfer(1'b1, LC, 32'h0000_02f0);
		chk("phy ctl", 32'h61, snap);
		strb <= 4'hf;
		xfer(1'b0, LC, 32'h0);
		chk("link control", 32'h203, q);
	endtask : t_fields
	task automatic t_modes;
		xfer(1'b1, plc_pkg::PORT_MODE_ADDR, 32'h2);
		xfer(1'b1, LC, 32'h200);
		xfer(1'b0, LC, 32'h0);
		chk("link control", 32'h0, q);
		xfer(1'b1, plc_pkg::PORT_MODE_ADDR, 32'h1);
		xfer(1'b1, LC, 32'h30);
		chk("phy ctl", 32'h0, snap);
		xfer(1'b1, plc_pkg::SWITCH_CONTROL_ADDR, 32'h1);
		xfer(1'b1, LC, 32'h30);
		chk("phy ctl", 32'h18, snap);
		xfer(1'b0, LC, 32'h0);
		chk("link control", 32'h10, q);
		xfer(1'b0, 12'h0fc, 32'h0);
		chk("error flag", 32'h1, {31'h0, e});
	endtask : t_modes
	task automatic t_recovery;
		xfer(1'b1, LC, 32'h20);
		chk("phy ctl", 32'h8, snap);
		repeat (2) @(posedge clk);
		xfer(1'b0, plc_pkg::PHY_STATUS_ADDR, 32'h0);
		chk("phy status", 32'h1, q);
		repeat (4) @(posedge clk);
		xfer(1'b0, plc_pkg::PHY_STATUS_ADDR, 32'h0);
		chk("phy status", 32'h0, q);
	endtask : t_recovery
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		xfer(1'b0, LC, 32'h0);
		chk("link control", 32'h0, q);
		t_eeprom;
		t_fields;
		t_modes;
		t_recovery;
		give_verdict;
	end
	initial
	begin
		#100000;
		miscompares++;
		give_verdict;
	end
endmodule : plc_link_control_tb
`default_nettype wire
